// ===== cms_consts.vh
`ifndef CMS_CONSTS_VH
`define CMS_CONSTS_VH

// Clock rate of the sequencer in MHz (20 ns period).
`define CMS_CLK_MHZ 50

// Dead time between one switch off and the other on, in ns.
`define CMS_DEAD_NS 40
// Dead time in clock cycles, rounded up.
`define CMS_DEAD_CYC ((`CMS_DEAD_NS * `CMS_CLK_MHZ + 999) / 1000)

// High time on the sync/shutdown input that qualifies a shutdown, in us.
`define CMS_SD_US 35
// Shutdown qualification time in clock cycles.
`define CMS_SD_CYC (`CMS_SD_US * `CMS_CLK_MHZ)

// Zero-current pulses that send the controller to sleep.
`define CMS_ZERO_SLEEP 7

// Least number of switching cycles run after a wake before sleep again.
`define CMS_BURST_MIN 10

// Switching cycles of the soft-start phase.
`define CMS_SS_CYCLES 64

// Least switching period in clock cycles accepted by the sequencer.
`define CMS_MIN_PERIOD 16'h0008

// Register byte offsets.
`define CMS_REG_PERIOD 4'h0
`define CMS_REG_ONTIME 4'h4
`define CMS_REG_STATUS 4'h8

// Register reset values.
`define CMS_PERIOD_RST 16'h0032
`define CMS_ONTIME_RST 16'h0014

// Status register field positions.
`define CMS_ST_STATE_LSB 0
`define CMS_ST_PFM_EN 2
`define CMS_ST_DCM_EN 3
`define CMS_ST_ZCNT_LSB 4
`define CMS_ST_BURST_DONE 7
`define CMS_ST_ENERG 8
`define CMS_ST_RECT 9
`define CMS_ST_SYNC 10

`endif

// ===== cms_conduction_mode_sequencer.v
// How it works
// - Light-load select high disables pulse-frequency mode; grounded enables it.
// - Two select inputs choose one of four conduction and light-load modes.
// - Sync input high past qualification time shuts down, both drives off.
// - In fixed PWM the rectifier turns on shortly after energizing switch off.
// - With DCM allowed rectifier turns off at zero current or a dead time before cycle end.
// - Forced CONDUCTION_SELECT ignores zero current; rectifier stays on until a dead time before cycle end.
// - Automatic mode runs fixed PWM until soft-start done and DCM edge seen.
// - At the DCM edge sleep until the feedback comparator reports low output.
// - After wake, run a burst of fixed PWM cycles before sleeping again.
// - In sleep, request power down of most internal circuitry.
// - Forced CONDUCTION_SELECT with LIGHT_LOAD_SELECT allowed still detects DCM and enters sleep.
// - Count zero-current pulses; sleep once seven have occurred.
// - Align the oscillator to each rising edge on the sync input that comes before the rectifier window closes.
// - Leaving shutdown restarts operation with a full soft-start.
// - Insert dead time so both switches are never on together.
`timescale 1ns/1ps
`default_nettype none
`include "cms_consts.vh"

module cms_conduction_mode_sequencer #(
  parameter SS_CYCLES = `CMS_SS_CYCLES, // Soft-start length in periods.
  parameter BURST_MIN = `CMS_BURST_MIN  // Least burst after a wake.
) (
  input wire clock_i, // System clock, 50 MHz.
  input wire reset_i, // Synchronous reset, active high.
  input wire sync_shutdown_input_i, // Sync pulses or shutdown level.
  input wire light_load_select_i, // High forces fixed PWM.
  input wire conduction_select_i, // High forces continuous conduction.
  input wire rectifier_sense_input_i, // Zero-current comparator output.
  input wire feedback_input_low_i, // Output is 2% below nominal.
  input wire [3:0] avs_address, // Register byte address.
  input wire avs_read, // Read request.
  input wire avs_write, // Write request.
  input wire [31:0] avs_writedata, // Write data.
  input wire [3:0] avs_byteenable, // Byte lanes of a write.
  output reg [31:0] avs_readdata, // Read data.
  output wire avs_waitrequest, // Stall of the current request.
  output reg energizing_drive_o, // Energizing switch gate drive.
  output reg rectifier_drive_o, // Synchronous rectifier gate drive.
  output reg sleep_o, // Power-down request for internal circuitry.
  output reg shutdown_o, // Controller is shut down.
  output reg soft_start_o // Soft-start phase is running.
);

  localparam ST_OFF = 2'b00;
  localparam ST_SOFT = 2'b01;
  localparam ST_RUN = 2'b10;
  localparam ST_SLEEP = 2'b11;

  localparam [15:0] DEAD = `CMS_DEAD_CYC;
  localparam [11:0] SD_LAST = `CMS_SD_CYC - 1;
  localparam [2:0] ZERO_LAST = `CMS_ZERO_SLEEP - 1;
  localparam [7:0] BURST_LAST = BURST_MIN;
  localparam [15:0] SS_LAST = SS_CYCLES - 1;

  reg [15:0] period_q;
  reg [15:0] period_d;
  reg [15:0] ontime_q;
  reg [15:0] ontime_d;
  reg ack_q;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [15:0] phase_q;
  reg [15:0] phase_d;
  reg [11:0] sd_cnt_q;
  reg sync_prev_q;
  reg zero_prev_q;
  reg zero_seen_q;
  reg [2:0] zcnt_q;
  reg [2:0] zcnt_d;
  reg [7:0] burst_q;
  reg [7:0] burst_d;
  reg [15:0] ss_cnt_q;
  reg [15:0] ss_cnt_d;

  wire pfm_en;
  wire dcm_en;
  wire running;
  wire [15:0] per;
  wire cycle_end;
  wire sync_rise;
  wire sd_hit;
  wire zero_rise;
  wire burst_done;
  wire [16:0] rect_start;
  wire [15:0] rect_stop;
  wire energ_d;
  wire rect_d;
  wire [31:0] status;

  // Decode the two static mode selects into the four operating modes.
  assign pfm_en = ~light_load_select_i;
  assign dcm_en = ~conduction_select_i;
  assign running = (state_q == ST_SOFT) | (state_q == ST_RUN);

  // Clamp the programmed period so the dead times always fit.
  assign per = (period_q < `CMS_MIN_PERIOD) ? `CMS_MIN_PERIOD : period_q;
  assign cycle_end = running & (phase_q >= per - 16'h0001);

  // Edges of the sync input and of the zero-current comparator.
  assign sync_rise = sync_shutdown_input_i & ~sync_prev_q;
  assign zero_rise = rectifier_sense_input_i & ~zero_prev_q &
                     rectifier_drive_o;

  // A high interval that reaches the threshold qualifies a shutdown.
  assign sd_hit = sync_shutdown_input_i & (sd_cnt_q == SD_LAST);

  assign burst_done = (burst_q == BURST_LAST);

  // Rectifier window opens a dead time after the energizing pulse ends.
  assign rect_start = {1'b0, ontime_q} + {1'b0, DEAD};
  // Rectifier window closes a dead time before the next cycle starts.
  assign rect_stop = per - DEAD;

  // Energizing pulse occupies the head of each switching cycle.
  assign energ_d = running & (phase_q < ontime_q);

  // Rectifier conducts in its window; zero current ends it when DCM is on.
  assign rect_d = running & ({1'b0, phase_q} >= rect_start) &
                  (phase_q < rect_stop) &
                  ~(dcm_en & (zero_seen_q | zero_rise));

  // Status word reflects the sequencer's own state.
  assign status = {21'h000000, sync_shutdown_input_i, rectifier_drive_o,
                   energizing_drive_o, burst_done, zcnt_q, dcm_en, pfm_en,
                   state_q};

  // Each request is stalled one cycle, then completes.
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;

  // Sequencer state: shutdown, soft-start, run and sleep.
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_OFF: begin
        if (!sync_shutdown_input_i) begin
          state_d = ST_SOFT;
        end
      end
      ST_SOFT: begin
        if (cycle_end && (ss_cnt_q == SS_LAST)) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (pfm_en && burst_done && zero_rise && (zcnt_q == ZERO_LAST)) begin
          state_d = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (!pfm_en || feedback_input_low_i) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_OFF;
      end
    endcase
    if (sd_hit) begin
      state_d = ST_OFF;
    end
  end

  // Oscillator phase: free running, pulled to a dead time before the cycle end by sync edges.
  always @* begin
    phase_d = phase_q;
    if (!running || (state_d != state_q)) begin
      phase_d = 16'h0000;
    end else if (sync_rise && (phase_q < rect_stop)) begin
      phase_d = rect_stop;
    end else if (cycle_end) begin
      phase_d = 16'h0000;
    end else begin
      phase_d = phase_q + 16'h0001;
    end
  end

  // Zero-current pulse count, cleared outside qualified run time.
  always @* begin
    zcnt_d = zcnt_q;
    if ((state_q != ST_RUN) || !pfm_en || !burst_done) begin
      zcnt_d = 3'h0;
    end else if (zero_rise) begin
      zcnt_d = zcnt_q + 3'h1;
    end
  end

  // Burst length in switching cycles since the last wake or restart.
  always @* begin
    burst_d = burst_q;
    if (state_q == ST_SLEEP || state_q == ST_OFF) begin
      burst_d = 8'h00;
    end else if (cycle_end && !burst_done) begin
      burst_d = burst_q + 8'h01;
    end
  end

  // Soft-start length in switching cycles.
  always @* begin
    ss_cnt_d = ss_cnt_q;
    if (state_q != ST_SOFT) begin
      ss_cnt_d = 16'h0000;
    end else if (cycle_end) begin
      ss_cnt_d = ss_cnt_q + 16'h0001;
    end
  end

  // Byte-lane merge of register writes.
  always @* begin
    period_d = period_q;
    ontime_d = ontime_q;
    if (ack_q && avs_write) begin
      if (avs_address == `CMS_REG_PERIOD) begin
        period_d[7:0] = avs_byteenable[0] ? avs_writedata[7:0] :
                        period_q[7:0];
        period_d[15:8] = avs_byteenable[1] ? avs_writedata[15:8] :
                         period_q[15:8];
      end else if (avs_address == `CMS_REG_ONTIME) begin
        ontime_d[7:0] = avs_byteenable[0] ? avs_writedata[7:0] :
                        ontime_q[7:0];
        ontime_d[15:8] = avs_byteenable[1] ? avs_writedata[15:8] :
                         ontime_q[15:8];
      end
    end
  end

  // Register bus slave: one wait cycle, read data loaded in that cycle.
  always @(posedge clock_i) begin
    if (reset_i) begin
      ack_q <= 1'b0;
      avs_readdata <= 32'h00000000;
      period_q <= `CMS_PERIOD_RST;
      ontime_q <= `CMS_ONTIME_RST;
    end else begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
      period_q <= period_d;
      ontime_q <= ontime_d;
      if (avs_read && !ack_q) begin
        if (avs_address == `CMS_REG_PERIOD) begin
          avs_readdata <= {16'h0000, period_q};
        end else if (avs_address == `CMS_REG_ONTIME) begin
          avs_readdata <= {16'h0000, ontime_q};
        end else if (avs_address == `CMS_REG_STATUS) begin
          avs_readdata <= status;
        end else begin
          avs_readdata <= 32'h00000000;
        end
      end
    end
  end

  // High-time counter of the sync/shutdown input.
  always @(posedge clock_i) begin
    if (reset_i) begin
      sd_cnt_q <= 12'h000;
    end else if (!sync_shutdown_input_i) begin
      sd_cnt_q <= 12'h000;
    end else if (sd_cnt_q != SD_LAST) begin
      sd_cnt_q <= sd_cnt_q + 12'h001;
    end
  end

  // Core sequencer registers.
  always @(posedge clock_i) begin
    if (reset_i) begin
      state_q <= ST_OFF;
      phase_q <= 16'h0000;
      sync_prev_q <= 1'b0;
      zero_prev_q <= 1'b0;
      zero_seen_q <= 1'b0;
      zcnt_q <= 3'h0;
      burst_q <= 8'h00;
      ss_cnt_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      phase_q <= phase_d;
      sync_prev_q <= sync_shutdown_input_i;
      zero_prev_q <= rectifier_sense_input_i;
      zcnt_q <= zcnt_d;
      burst_q <= burst_d;
      ss_cnt_q <= ss_cnt_d;
      // With DCM on, a zero crossing blanks the rectifier for the rest of the cycle.
      if (cycle_end || !running) begin
        zero_seen_q <= 1'b0;
      end else if (zero_rise) begin
        zero_seen_q <= 1'b1;
      end
    end
  end

  // Registered gate drives and mode flags.
  always @(posedge clock_i) begin
    if (reset_i) begin
      energizing_drive_o <= 1'b0;
      rectifier_drive_o <= 1'b0;
      sleep_o <= 1'b0;
      shutdown_o <= 1'b1;
      soft_start_o <= 1'b0;
    end else begin
      // Both drives are forced off in the cycle a shutdown qualifies, and are off from the second cycle of sleep.
      energizing_drive_o <= energ_d & ~sd_hit;
      rectifier_drive_o <= rect_d & ~sd_hit;
      sleep_o <= (state_d == ST_SLEEP);
      shutdown_o <= (state_d == ST_OFF);
      soft_start_o <= (state_d == ST_SOFT);
    end
  end

endmodule // cms_conduction_mode_sequencer
`default_nettype wire

// ===== cms_seq_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module cms_seq_monitor (
  input wire logic clock_i, // Clock.
  input wire logic reset_i, // Synchronous reset.
  input wire logic sync_shutdown_input_i, // Sync or shutdown level.
  input wire logic light_load_select_i, // High forces fixed PWM.
  input wire logic conduction_select_i, // High forces CONDUCTION_SELECT.
  input wire logic rectifier_sense_input_i, // Zero-current comparator.
  input wire logic feedback_input_low_i, // Output below nominal.
  input wire logic avs_read, // Bus read.
  input wire logic avs_waitrequest, // Bus stall.
  input wire logic energizing_drive_o, // Energizing gate.
  input wire logic rectifier_drive_o, // Rectifier gate.
  input wire logic sleep_o, // Sleep request.
  input wire logic shutdown_o, // Shut down.
  input wire logic soft_start_o // Soft-start running.
);
  logic [11:0] hi_cnt_q;
  // Counts consecutive high samples of the sync input, saturating.
  always_ff @(posedge clock_i) begin
    if (reset_i || !sync_shutdown_input_i) hi_cnt_q <= 12'h000;
    else if (hi_cnt_q != 12'hFFF) hi_cnt_q <= hi_cnt_q + 12'h001;
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);
  AST_NO_OVERLAP: assert property (!(energizing_drive_o && rectifier_drive_o))
    else $error("both switches on");
  AST_SD_EARLY: assert property ($rose(shutdown_o) && !$past(reset_i)
    |-> hi_cnt_q >= 12'h6D5) else $error("shutdown too early");
  AST_SD_LATE: assert property (hi_cnt_q == 12'h6E0 |-> shutdown_o)
    else $error("shutdown missing");
  AST_SD_DRIVES: assert property (shutdown_o ##1 shutdown_o
    |-> !energizing_drive_o && !rectifier_drive_o) else $error("drive in off");
  AST_SLEEP_DRIVES: assert property (sleep_o ##1 sleep_o
    |-> !energizing_drive_o && !rectifier_drive_o) else $error("drive asleep");
  AST_DCM_CUT: assert property (!conduction_select_i && rectifier_drive_o
    && $rose(rectifier_sense_input_i) |-> ##[1:2] !rectifier_drive_o)
    else $error("rectifier not cut");
  AST_CCM_HOLD: assert property (conduction_select_i && light_load_select_i
    && rectifier_drive_o && $rose(rectifier_sense_input_i) |=> rectifier_drive_o)
    else $error("rectifier cut in ccm");
  AST_PWM_AWAKE: assert property (light_load_select_i[*3] |-> !sleep_o)
    else $error("sleep in fixed pwm");
  AST_WAKE: assert property (sleep_o && feedback_input_low_i
    |-> ##[1:3] !sleep_o) else $error("no wake");
  AST_SYNC_ALIGN: assert property ($rose(sync_shutdown_input_i)
    && energizing_drive_o && !shutdown_o |-> ##[1:3] !energizing_drive_o)
    else $error("sync not aligned");
  AST_RESTART: assert property ($fell(shutdown_o) |-> ##[0:2] soft_start_o)
    else $error("no soft start");
  AST_BUS_WAIT: assert property ($rose(avs_read) |-> avs_waitrequest
    ##1 !avs_waitrequest) else $error("bus wait wrong");
  COV_SLEEP: cover property ($rose(sleep_o));
  COV_WAKE: cover property ($fell(sleep_o));
  COV_SD: cover property ($rose(shutdown_o));
endmodule // cms_seq_monitor
bind cms_conduction_mode_sequencer cms_seq_monitor i_mon (.clock_i(clock_i),
  .reset_i(reset_i), .sync_shutdown_input_i(sync_shutdown_input_i),
  .light_load_select_i(light_load_select_i),
  .conduction_select_i(conduction_select_i),
  .rectifier_sense_input_i(rectifier_sense_input_i),
  .feedback_input_low_i(feedback_input_low_i), .avs_read(avs_read),
  .avs_waitrequest(avs_waitrequest), .energizing_drive_o(energizing_drive_o),
  .rectifier_drive_o(rectifier_drive_o), .sleep_o(sleep_o),
  .shutdown_o(shutdown_o), .soft_start_o(soft_start_o));
`default_nettype wire

// ===== cms_power_stage_model.sv
`timescale 1ns/1ps
`default_nettype none
module cms_power_stage_model (
  input wire logic clock_i, // Clock.
  input wire logic rectifier_drive_i, // Rectifier gate.
  input wire logic sleep_i, // Controller asleep.
  input wire logic light_i, // Light load, current reaches zero.
  output logic zero_o, // Zero-current comparator.
  output logic fb_low_o // Output sagged below nominal.
);
  logic [7:0] rc_q;
  logic [7:0] sc_q;
  // Time spent with the rectifier on and with the controller asleep.
  always_ff @(posedge clock_i) begin
    rc_q <= rectifier_drive_i ? rc_q + 8'h01 : 8'h00;
    sc_q <= sleep_i ? sc_q + 8'h01 : 8'h00;
  end
  // Under light load the current runs dry eight cycles into the rectifier pulse.
  assign zero_o = light_i && (rc_q >= 8'h08);
  // With no switching the output droops past the wake threshold.
  assign fb_low_o = (sc_q >= 8'h1E);
endmodule // cms_power_stage_model
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clock_i = 1'b0, reset_i = 1'b1, sync = 1'b0, ll = 1'b1, cs = 1'b0;
  logic rd = 1'b0, wr = 1'b0, light = 1'b1, sense, fb;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic wait_rq, en, re, slp, sd, ss;
  int err_total = 0, num_checks = 0;
  cms_conduction_mode_sequencer #(.SS_CYCLES(2), .BURST_MIN(2)) i_dut (
    .clock_i(clock_i), .reset_i(reset_i), .sync_shutdown_input_i(sync),
    .light_load_select_i(ll), .conduction_select_i(cs),
    .rectifier_sense_input_i(sense), .feedback_input_low_i(fb),
    .avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
    .avs_byteenable(4'hF), .avs_readdata(rdata), .avs_waitrequest(wait_rq),
    .energizing_drive_o(en), .rectifier_drive_o(re), .sleep_o(slp),
    .shutdown_o(sd), .soft_start_o(ss));
  cms_power_stage_model i_stage (.clock_i(clock_i), .rectifier_drive_i(re),
    .sleep_i(slp), .light_i(light), .zero_o(sense), .fb_low_o(fb));
  // Free-running 50 MHz clock.
  always #10 clock_i = ~clock_i;
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One Avalon transfer, held until waitrequest is sampled low.
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    addr <= a;
    wdata <= d;
    rd <= !w;
    wr <= w;
    do begin
      @(posedge clock_i);
      n++;
    end while (wait_rq !== 1'b0 && n < 50);
    // A request that never completes counts as a mismatch.
    if (n >= 50) err_total++;
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clock_i);
  endtask
  function automatic logic pick(input int s);
    return s == 0 ? ss : (s == 1 ? slp : sd);
  endfunction
  // Waits, bounded, for soft-start, sleep or shutdown to reach a level.
  task automatic wait_sig(input int s, input logic v);
    int n;
    n = 0;
    while (pick(s) !== v && n < 3000) begin
      @(posedge clock_i);
      n++;
    end
    chk({31'h0, pick(s)}, {31'h0, v});
  endtask
  task automatic do_reset(input logic l, input logic c);
    ll <= l;
    cs <= c;
    reset_i <= 1'b1;
    repeat (10) @(posedge clock_i);
    reset_i <= 1'b0;
    wait_sig(0, 1'b1);
    wait_sig(0, 1'b0);
  endtask
  // Counts gate-on samples over one period from an energizing rise.
  task automatic meas(output logic [31:0] e, output logic [31:0] r);
    int n;
    n = 0;
    e = 0;
    r = 0;
    while (en !== 1'b0 && n < 200) begin @(posedge clock_i); n++; end
    while (en !== 1'b1 && n < 400) begin @(posedge clock_i); n++; end
    repeat (50) begin
      if (en === 1'b1) e++;
      if (re === 1'b1) r++;
      @(posedge clock_i);
    end
  endtask
  task automatic t_regs;
    logic [31:0] d;
    bus(1'b0, 4'h0, 32'h0, d);
    chk(d, 32'h0000_0032);
    bus(1'b0, 4'h4, 32'h0, d);
    chk(d, 32'h0000_0014);
    bus(1'b1, 4'hC, 32'h1234_5678, d);
    bus(1'b0, 4'hC, 32'h0, d);
    chk(d, 32'h0000_0000);
    bus(1'b1, 4'h0, 32'hFFFF_0040, d);
    bus(1'b0, 4'h0, 32'h0, d);
    chk(d, 32'h0000_0040);
    bus(1'b1, 4'h0, 32'h0000_0032, d);
    $display("test regs done");
  endtask
  task automatic t_fixed(input logic c);
    logic [31:0] e, r, d;
    do_reset(1'b1, c);
    meas(e, r);
    chk(e, 32'h0000_0014);
    if (c) chk(r, 32'h0000_001A);
    else chk({31'h0, r < 32'h1A}, 32'h1);
    chk(32'h32 - e - r, c ? 32'h4 : 32'h15);
    bus(1'b0, 4'h8, 32'h0, d);
    chk(d & 32'hFFFF_FCFF, c ? 32'h0000_0082 : 32'h0000_008A);
    repeat (400) @(posedge clock_i);
    chk({31'h0, slp}, 32'h0);
    $display("test fixed pwm done");
  endtask
  task automatic t_pfm(input logic c);
    logic [31:0] e, r;
    do_reset(1'b0, c);
    wait_sig(1, 1'b1);
    @(posedge clock_i);
    chk({30'h0, en, re}, 32'h0);
    wait_sig(1, 1'b0);
    meas(e, r);
    chk(e, 32'h0000_0014);
    wait_sig(1, 1'b1);
    $display("test pfm done");
  endtask
  task automatic t_sync;
    do_reset(1'b1, 1'b1);
    while (en !== 1'b1) @(posedge clock_i);
    sync <= 1'b1;
    repeat (6) @(posedge clock_i);
    sync <= 1'b0;
    repeat (100) @(posedge clock_i);
    chk({31'h0, sd}, 32'h0);
    sync <= 1'b1;
    wait_sig(2, 1'b1);
    repeat (2) @(posedge clock_i);
    chk({30'h0, en, re}, 32'h0);
    sync <= 1'b0;
    wait_sig(0, 1'b1);
    wait_sig(0, 1'b0);
    chk({31'h0, sd}, 32'h0);
    $display("test sync done");
  endtask
  initial begin
    repeat (10) @(posedge clock_i);
    reset_i <= 1'b0;
    @(posedge clock_i);
    t_regs();
    t_fixed(1'b0);
    t_fixed(1'b1);
    t_pfm(1'b0);
    t_pfm(1'b1);
    t_sync();
    conclude();
  end
  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (40000) @(posedge clock_i);
    err_total++;
    conclude();
  end
endmodule // testbench
`default_nettype wire
